// ### rtl/mixer_gain_pkg.sv
package mixer_gain_pkg;
	localparam logic [7:0]  MIC_PAIR_GAIN_ADDR   = 8'h0E;
	localparam logic [7:0]  LINE_INPUT_GAIN_ADDR = 8'h10;
	localparam logic [7:0]  CD_INPUT_GAIN_ADDR   = 8'h12;
	localparam logic [7:0]  BOOST_SELECT_ADDR    = 8'h76;
	localparam logic [15:0] GAIN_RESET           = 16'h8888;
	localparam logic [15:0] GAIN_WRITE_MASK      = 16'h9F9F;
	localparam logic [15:0] MIC_WRITE_MASK       = 16'h9FDF;
	localparam logic [15:0] BOOST_WRITE_MASK     = 16'h0003;
	localparam logic [15:0] BOOST_RESET          = 16'h0000;
	localparam int          LEFT_SILENCE_POS     = 15;
	localparam int          LEFT_CODE_LSB        = 8;
	localparam int          RIGHT_SILENCE_POS    = 7;
	localparam int          BOOST_ENABLE_POS     = 6;
	localparam int          RIGHT_CODE_LSB       = 0;
	localparam int          CODE_WIDTH           = 5;
	// Boost steps presented to the analog stage
	typedef enum logic [1:0] {BOOST_OFF, BOOST_10DB, BOOST_20DB, BOOST_30DB} boost_t;
	// Attenuation in 1.5 dB steps; code 8 is unity, code 0 is +12 dB
	typedef struct packed {
		logic                  silence;
		logic [CODE_WIDTH-1:0] code;
	} channel_t;
	typedef struct packed {
		channel_t left;
		channel_t right;
	} stereo_t;
endpackage

// ### rtl/gain_register.sv
`timescale 1ns/1ps
`default_nettype none
module gain_register
	import mixer_gain_pkg::*;
#(
	parameter logic [15:0] RESET_VALUE = GAIN_RESET,
	parameter logic [15:0] WRITE_MASK  = GAIN_WRITE_MASK
) (
	input  wire logic        clock,    // System clock
	input  wire logic        srst,     // Synchronous reset
	input  wire logic        writeHit, // Write to this register
	input  wire logic [15:0] writeData, // Write data
	output var  logic [15:0] value     // Stored value, reserved bits zero
);
	logic [15:0] next_value;

	// Reset bits outside the mask could never be rewritten and would break read-as-zero
	if ((RESET_VALUE & ~WRITE_MASK) != 16'h0000) begin : g_reset_in_mask
		$error("reset value sets bits outside the write mask");
	end

	// Only implemented bits are stored so reserved bits always read zero
	always_comb begin
		next_value = value;
		if (writeHit) begin
			next_value = writeData & WRITE_MASK;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			value <= RESET_VALUE;
		end else begin
			value <= next_value;
		end
	end
endmodule
`default_nettype wire

// ### rtl/mixer_input_gain_registers.sv
// Functional notes
// - Three 16-bit gain registers at 0x0E, 0x10, 0x12 with mute and volume fields.
// - Each five-bit volume code is one of 32 steps of 1.5 dB.
// - Code 0 is +12 dB, code 8 is 0 dB, code 31 is -34.5 dB.
// - Mic register drives left and right mic gain, boost, independent mutes.
// - Mic bit 6 enables shared boost; select 00 gives 20 dB, 01 gives 10 dB.
// - Boost select field at 0x76 moves boost to 10 dB or 30 dB.
// - Mixer input gains are independent of the record gain at 0x1C.
// - CD register only affects the analog CD input path.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module mixer_input_gain_registers
	import mixer_gain_pkg::*;
(
	input  wire logic        clock,      // 10 MHz system clock
	input  wire logic        srst,       // Synchronous reset, active high
	input  wire logic [7:0]  address,    // Register address
	input  wire logic [15:0] writeData,  // Write data
	input  wire logic        writeStrobe, // One-cycle write strobe
	input  wire logic        readStrobe, // One-cycle read strobe
	output var  logic [15:0] readData,   // Read data, valid cycle after strobe
	output var  stereo_t     micGain,    // Left and right microphone channels
	output var  boost_t      micBoost,   // Shared microphone boost
	output var  stereo_t     lineGain,   // Line input channels
	output var  stereo_t     cdGain      // Analog CD input channels
);
	logic [15:0] micValue;
	logic [15:0] lineValue;
	logic [15:0] cdValue;
	logic [15:0] boostValue;
	logic [15:0] next_readData;
	stereo_t     next_micGain;
	stereo_t     next_lineGain;
	stereo_t     next_cdGain;
	boost_t      next_micBoost;

	// Boost select field and its codes; the fourth code is taken as boost off
	localparam int          SELECT_LSB   = 0;
	localparam int          SELECT_WIDTH = 2;
	localparam logic [1:0]  SELECT_20DB  = 2'h0;
	localparam logic [1:0]  SELECT_10DB  = 2'h1;
	localparam logic [1:0]  SELECT_30DB  = 2'h2;
	localparam logic [15:0] READ_IDLE    = 16'h0000;
	logic [SELECT_WIDTH-1:0] boostSelect;

	// Field layout must fit the word without fields running into each other
	localparam bit LAYOUT_BAD = (LEFT_CODE_LSB + CODE_WIDTH > LEFT_SILENCE_POS)
		|| (RIGHT_CODE_LSB + CODE_WIDTH > BOOST_ENABLE_POS);
	if (LAYOUT_BAD) begin : g_layout_check
		$error("gain field layout overlaps");
	end

	// Storage; 0x1C is not decoded here, so record gain cannot disturb these
	gain_register #(.RESET_VALUE(GAIN_RESET), .WRITE_MASK(MIC_WRITE_MASK)) micReg (
		.clock    (clock),
		.srst     (srst),
		.writeHit (writeStrobe && address == MIC_PAIR_GAIN_ADDR),
		.writeData(writeData),
		.value    (micValue)
	);
	gain_register #(.RESET_VALUE(GAIN_RESET), .WRITE_MASK(GAIN_WRITE_MASK)) lineReg (
		.clock    (clock),
		.srst     (srst),
		.writeHit (writeStrobe && address == LINE_INPUT_GAIN_ADDR),
		.writeData(writeData),
		.value    (lineValue)
	);
	gain_register #(.RESET_VALUE(GAIN_RESET), .WRITE_MASK(GAIN_WRITE_MASK)) cdReg (
		.clock    (clock),
		.srst     (srst),
		.writeHit (writeStrobe && address == CD_INPUT_GAIN_ADDR),
		.writeData(writeData),
		.value    (cdValue)
	);
	// Boost select lives here so the boost decode can see it
	gain_register #(.RESET_VALUE(BOOST_RESET), .WRITE_MASK(BOOST_WRITE_MASK)) boostReg (
		.clock    (clock),
		.srst     (srst),
		.writeHit (writeStrobe && address == BOOST_SELECT_ADDR),
		.writeData(writeData),
		.value    (boostValue)
	);

	function automatic stereo_t unpack(input logic [15:0] v);
		stereo_t s;
		s.left.silence  = v[LEFT_SILENCE_POS];
		s.left.code     = v[LEFT_CODE_LSB +: CODE_WIDTH];
		s.right.silence = v[RIGHT_SILENCE_POS];
		s.right.code    = v[RIGHT_CODE_LSB +: CODE_WIDTH];
		return s;
	endfunction

	// Only the low select bits are stored, the rest of 0x76 reads zero
	assign boostSelect = boostValue[SELECT_LSB +: SELECT_WIDTH];

	// Read mux and analog control decode; unmapped reads return zero
	always_comb begin
		next_readData = READ_IDLE;
		if (readStrobe) begin
			case (address)
				MIC_PAIR_GAIN_ADDR:   next_readData = micValue;
				LINE_INPUT_GAIN_ADDR: next_readData = lineValue;
				CD_INPUT_GAIN_ADDR:   next_readData = cdValue;
				BOOST_SELECT_ADDR:    next_readData = boostValue;
				default:              next_readData = READ_IDLE;
			endcase
		end
		// Codes pass straight through: each step is 1.5 dB, 8 is unity
		next_micGain  = unpack(micValue);
		next_lineGain = unpack(lineValue);
		next_cdGain   = unpack(cdValue);
		// Boost is shared by both mic channels, each mute still independent
		next_micBoost = BOOST_OFF;
		if (micValue[BOOST_ENABLE_POS]) begin
			case (boostSelect)
				SELECT_20DB: next_micBoost = BOOST_20DB;
				SELECT_10DB: next_micBoost = BOOST_10DB;
				SELECT_30DB: next_micBoost = BOOST_30DB;
				default:     next_micBoost = BOOST_OFF;
			endcase
		end
	end

	// Outputs registered; analog settings follow a write by two cycles, one after the register
	always_ff @(posedge clock) begin
		if (srst) begin
			readData <= READ_IDLE;
			micGain  <= unpack(GAIN_RESET);
			lineGain <= unpack(GAIN_RESET);
			cdGain   <= unpack(GAIN_RESET);
			micBoost <= BOOST_OFF;
		end else begin
			readData <= next_readData;
			micGain  <= next_micGain;
			lineGain <= next_lineGain;
			cdGain   <= next_cdGain;
			micBoost <= next_micBoost;
		end
	end

	a_reserved_zero: assert property (@(posedge clock) disable iff (srst)
		(micValue & ~MIC_WRITE_MASK) == 16'h0000 && (cdValue & ~GAIN_WRITE_MASK) == 16'h0000
			&& (lineValue & ~GAIN_WRITE_MASK) == 16'h0000)
		else $error("reserved bits set");
	a_reset_value: assert property (@(posedge clock)
		$past(srst) |-> lineValue == GAIN_RESET && micValue == GAIN_RESET)
		else $error("reset value wrong");
	a_mic_write: assert property (@(posedge clock) disable iff (srst)
		writeStrobe && address == MIC_PAIR_GAIN_ADDR |=> micValue == ($past(writeData) & MIC_WRITE_MASK))
		else $error("mic write lost");
	a_read_back: assert property (@(posedge clock) disable iff (srst)
		readStrobe && address == CD_INPUT_GAIN_ADDR |=> readData == $past(cdValue))
		else $error("cd read wrong");
	a_boost_off: assert property (@(posedge clock) disable iff (srst)
		!micValue[BOOST_ENABLE_POS] |=> micBoost == BOOST_OFF)
		else $error("boost not off");
	a_boost_sel: assert property (@(posedge clock) disable iff (srst)
		micValue[BOOST_ENABLE_POS] && boostSelect == SELECT_10DB |=> micBoost == BOOST_10DB)
		else $error("boost select wrong");
	a_mic_mute: assert property (@(posedge clock) disable iff (srst)
		1'b1 |=> micGain.left.silence == $past(micValue[LEFT_SILENCE_POS])
			&& micGain.right.code == $past(micValue[RIGHT_CODE_LSB +: CODE_WIDTH]))
		else $error("mic fields wrong");
	a_line_code: assert property (@(posedge clock) disable iff (srst)
		1'b1 |=> lineGain.left.code == $past(lineValue[LEFT_CODE_LSB +: CODE_WIDTH]))
		else $error("line code wrong");

	// Each store holds unless its own address is written, so other writes cannot leak in
	a_mic_hold: assert property (@(posedge clock) disable iff (srst)
		!(writeStrobe && address == MIC_PAIR_GAIN_ADDR) |=> $stable(micValue))
		else $error("mic register changed without a write");
	a_line_hold: assert property (@(posedge clock) disable iff (srst)
		!(writeStrobe && address == LINE_INPUT_GAIN_ADDR) |=> $stable(lineValue))
		else $error("line register changed without a write");
	a_cd_hold: assert property (@(posedge clock) disable iff (srst)
		!(writeStrobe && address == CD_INPUT_GAIN_ADDR) |=> $stable(cdValue))
		else $error("cd register changed without a write");

	// Writes land masked in the cycle after the strobe
	a_line_write: assert property (@(posedge clock) disable iff (srst)
		writeStrobe && address == LINE_INPUT_GAIN_ADDR |=> lineValue == ($past(writeData) & GAIN_WRITE_MASK))
		else $error("line write lost");
	a_cd_write: assert property (@(posedge clock) disable iff (srst)
		writeStrobe && address == CD_INPUT_GAIN_ADDR |=> cdValue == ($past(writeData) & GAIN_WRITE_MASK))
		else $error("cd write lost");

	// Read data stand only in the cycle after the strobe
	a_mic_read: assert property (@(posedge clock) disable iff (srst)
		readStrobe && address == MIC_PAIR_GAIN_ADDR |=> readData == $past(micValue))
		else $error("mic read wrong");
	a_line_read: assert property (@(posedge clock) disable iff (srst)
		readStrobe && address == LINE_INPUT_GAIN_ADDR |=> readData == $past(lineValue))
		else $error("line read wrong");
	a_read_idle: assert property (@(posedge clock) disable iff (srst)
		!readStrobe |=> readData == READ_IDLE)
		else $error("read data without a read");
	a_unmapped_read: assert property (@(posedge clock) disable iff (srst)
		readStrobe && address != MIC_PAIR_GAIN_ADDR && address != LINE_INPUT_GAIN_ADDR
			&& address != CD_INPUT_GAIN_ADDR && address != BOOST_SELECT_ADDR |=> readData == READ_IDLE)
		else $error("unmapped read not zero");

	// Remaining boost steps and reset values
	a_boost_nominal: assert property (@(posedge clock) disable iff (srst)
		micValue[BOOST_ENABLE_POS] && boostSelect == SELECT_20DB |=> micBoost == BOOST_20DB)
		else $error("nominal boost wrong");
	a_boost_high: assert property (@(posedge clock) disable iff (srst)
		micValue[BOOST_ENABLE_POS] && boostSelect == SELECT_30DB |=> micBoost == BOOST_30DB)
		else $error("high boost wrong");
	a_reset_rest: assert property (@(posedge clock)
		$past(srst) |-> cdValue == GAIN_RESET && boostValue == BOOST_RESET)
		else $error("cd or boost reset value wrong");

	// Analog fields follow their register one cycle later
	a_mic_fields: assert property (@(posedge clock) disable iff (srst)
		1'b1 |=> micGain.left.code == $past(micValue[LEFT_CODE_LSB +: CODE_WIDTH])
			&& micGain.right.silence == $past(micValue[RIGHT_SILENCE_POS]))
		else $error("mic left code or right mute wrong");
	a_line_fields: assert property (@(posedge clock) disable iff (srst)
		1'b1 |=> lineGain.right.code == $past(lineValue[RIGHT_CODE_LSB +: CODE_WIDTH])
			&& lineGain.left.silence == $past(lineValue[LEFT_SILENCE_POS])
			&& lineGain.right.silence == $past(lineValue[RIGHT_SILENCE_POS]))
		else $error("line fields wrong");
	a_cd_fields: assert property (@(posedge clock) disable iff (srst)
		1'b1 |=> cdGain.left.code == $past(cdValue[LEFT_CODE_LSB +: CODE_WIDTH])
			&& cdGain.right.code == $past(cdValue[RIGHT_CODE_LSB +: CODE_WIDTH])
			&& cdGain.left.silence == $past(cdValue[LEFT_SILENCE_POS])
			&& cdGain.right.silence == $past(cdValue[RIGHT_SILENCE_POS]))
		else $error("cd fields wrong");
endmodule
`default_nettype wire

// ### tb/mixer_input_gain_registers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mixer_input_gain_registers_tb_top
	import mixer_gain_pkg::*;
;
	logic        clock;
	logic        srst;
	logic [7:0]  address;
	logic [15:0] writeData;
	logic        writeStrobe;
	logic        readStrobe;
	logic [15:0] readData;
	stereo_t     micGain;
	boost_t      micBoost;
	stereo_t     lineGain;
	stereo_t     cdGain;
	int          bad_count;
	int          num_checks;
	mixer_input_gain_registers u_mixer_input_gain_registers (.clock(clock), .srst(srst),
		.address(address), .writeData(writeData), .writeStrobe(writeStrobe),
		.readStrobe(readStrobe), .readData(readData), .micGain(micGain),
		.micBoost(micBoost), .lineGain(lineGain), .cdGain(cdGain));
	// 100 ns clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Channel fields as the analog side should see them
	function automatic logic [15:0] st(input logic [15:0] d);
		return {4'h0, d[15], d[12:8], d[7], d[4:0]};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		writeStrobe <= 1'b1;
		address     <= a;
		writeData   <= d;
		@(posedge clock);
		writeStrobe <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock);
		readStrobe <= 1'b1;
		address    <= a;
		@(posedge clock);
		readStrobe <= 1'b0;
		#1 check(readData, e);
	endtask
	// Output flop lands one cycle after the register
	task automatic settle();
		@(posedge clock);
		#1;
	endtask
	task automatic test_reset();
		srst <= 1'b1;
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		settle();
		check(readData, 16'h0000);
		check({4'h0, micGain}, st(GAIN_RESET));
		check({14'h0, micBoost}, {14'h0, BOOST_OFF});
		check({4'h0, lineGain}, st(16'h8888));
		check({4'h0, cdGain}, st(16'h8888));
		rd(MIC_PAIR_GAIN_ADDR, 16'h8888);
		rd(LINE_INPUT_GAIN_ADDR, 16'h8888);
		rd(CD_INPUT_GAIN_ADDR, 16'h8888);
		$display("test_reset done");
	endtask
	// Reserved bits are dropped; unmapped places are inert
	task automatic test_mask();
		wr(MIC_PAIR_GAIN_ADDR, 16'hFFFF);
		wr(LINE_INPUT_GAIN_ADDR, 16'hFFFF);
		wr(CD_INPUT_GAIN_ADDR, 16'hFFFF);
		wr(8'h14, 16'h0000);
		wr(8'h1C, 16'h0000);
		rd(MIC_PAIR_GAIN_ADDR, 16'h9FDF);
		rd(LINE_INPUT_GAIN_ADDR, 16'h9F9F);
		rd(CD_INPUT_GAIN_ADDR, 16'h9F9F);
		rd(8'h14, 16'h0000);
		settle();
		check(readData, 16'h0000);
		check({4'h0, cdGain}, st(16'h9F9F));
		$display("test_mask done");
	endtask
	// Extreme codes and independent silence bits per channel
	task automatic test_codes();
		wr(LINE_INPUT_GAIN_ADDR, 16'h001F);
		wr(CD_INPUT_GAIN_ADDR, 16'h0880);
		settle();
		check({4'h0, lineGain}, st(16'h001F));
		check({4'h0, cdGain}, st(16'h0880));
		check({4'h0, micGain}, st(16'h9FDF));
		$display("test_codes done");
	endtask
	// Shared boost under every select code, then disabled
	task automatic test_boost();
		boost_t exp[4];
		exp = '{BOOST_20DB, BOOST_10DB, BOOST_30DB, BOOST_OFF};
		wr(MIC_PAIR_GAIN_ADDR, 16'h0848);
		for (int i = 0; i < 4; i++) begin
			wr(BOOST_SELECT_ADDR, 16'(i));
			settle();
			check({14'h0, micBoost}, {14'h0, exp[i]});
		end
		check({4'h0, micGain}, st(16'h0848));
		wr(BOOST_SELECT_ADDR, 16'h0000);
		wr(MIC_PAIR_GAIN_ADDR, 16'h0808);
		settle();
		check({14'h0, micBoost}, {14'h0, BOOST_OFF});
		$display("test_boost done");
	endtask
	task automatic results();
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Tests need well under 200 cycles
	initial begin
		#100000;
		bad_count++;
		results();
	end
	initial begin
		bad_count = 0;
		num_checks = 0;
		srst = 1'b1;
		address = 8'h00;
		writeData = 16'h0000;
		writeStrobe = 1'b0;
		readStrobe = 1'b0;
		test_reset();
		test_mask();
		test_codes();
		test_boost();
		// Raise the mid-run reset on an edge so it is sampled for four full edges
		@(posedge clock);
		test_reset();
		results();
	end
endmodule
`default_nettype wire
